// ==== tb/test_cfm_core_cfg.sv ====
// self-checking bench for the core feature registers and segment map
// assumes the default region windows and the defines header on the include path
`timescale 1ns/10ps
`default_nettype none

module test_cfm_core_cfg;
    localparam int LIMIT = 3000;
    logic clock_in = 1'h0;
    logic rst_in = 1'h1;
    cfm_pkg::cfm_cp0_sel_t rd_sel = '0;
    cfm_pkg::cfm_cp0_sel_t wr_sel = '0;
    logic [31:0] rd_data;
    logic rd_hit, wr_hit, error_level_flag;
    logic soft_reset = 1'h0;
    logic nmi = 1'h0;
    logic erl_clear = 1'h0;
    logic cpu_req = 1'h0;
    logic cpu_fetch = 1'h0;
    logic [31:0] cpu_vaddr = 32'h0;
    logic dma_req = 1'h0;
    logic [31:0] dma_addr = 32'h0;
    cfm_pkg::cfm_map_t cpu_map, dma_map;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int k;

    cfm_core_cfg cfm_core_cfg_inst (
        .clock_in(clock_in), .rst_in(rst_in),
        .rd_sel_in(rd_sel), .rd_data_out(rd_data), .rd_hit_out(rd_hit),
        .wr_sel_in(wr_sel), .wr_hit_out(wr_hit),
        .soft_reset_in(soft_reset), .nmi_in(nmi), .erl_clear_in(erl_clear), .erl_out(error_level_flag),
        .cpu_req_in(cpu_req), .cpu_fetch_in(cpu_fetch), .cpu_vaddr_in(cpu_vaddr),
        .cpu_map_out(cpu_map),
        .dma_req_in(dma_req), .dma_addr_in(dma_addr), .dma_map_out(dma_map)
    );

    initial begin
        forever #50 clock_in = ~clock_in;
    end

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // answer stands only in the cycle after the request, so sample there
    task automatic rd(input logic [4:0] num, input logic [2:0] sel, input logic [31:0] exp,
                      input logic hit);
        @(negedge clock_in);
        rd_sel = '{en: 1'h1, num: num, sel: sel};
        @(negedge clock_in);
        rd_sel = '0;
        check("rd_data", rd_data, exp);
        check("rd_hit", {31'h0, rd_hit}, {31'h0, hit});
    endtask

    task automatic wr(input logic [2:0] sel);
        @(negedge clock_in);
        wr_sel = '{en: 1'h1, num: 5'h10, sel: sel};
        @(negedge clock_in);
        wr_sel = '0;
        check("wr_hit", {31'h0, wr_hit}, 32'h1);
    endtask

    task automatic erl_ctl(input logic sr, input logic nm, input logic clr, input logic exp);
        @(negedge clock_in);
        soft_reset = sr;
        nmi = nm;
        erl_clear = clr;
        @(negedge clock_in);
        {soft_reset, nmi, erl_clear} = 3'h0;
        check("erl_out", {31'h0, error_level_flag}, {31'h0, exp});
    endtask

    task automatic xl(input logic dma, input logic [31:0] va, input logic fetch,
                      input logic flt, input cfm_pkg::cfm_region_t rg, input logic [31:0] pa);
        cfm_pkg::cfm_map_t m;
        @(negedge clock_in);
        cpu_req = ~dma;
        dma_req = dma;
        cpu_vaddr = va;
        dma_addr = va;
        cpu_fetch = fetch;
        @(negedge clock_in);
        {cpu_req, dma_req, cpu_fetch} = 3'h0;
        m = dma ? dma_map : cpu_map;
        check("map_valid", {31'h0, m.valid}, 32'h1);
        check("map_fault", {31'h0, m.fault}, {31'h0, flt});
        check("map_fetch", {31'h0, m.fetch}, {31'h0, fetch & ~dma});
        if (!flt) begin
            check("map_region", {29'h0, m.region}, {29'h0, rg});
            check("map_paddr", m.paddr, pa);
        end
    endtask

    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            complete_run();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (3) @(negedge clock_in);
        check("erl_reset", {31'h0, error_level_flag}, 32'h1);
        rst_in = 1'h0;
        @(negedge clock_in);
        rd(5'h10, 3'h1, 32'h8000_0000 | 32'h10 | 32'h2, 1'h1);
        rd(5'h10, 3'h3, 32'h0020_0000 | 32'h0003_0000 | 32'h4000 | 32'h3000
           | 32'h60 | 32'h8, 1'h1);
        rd(5'h10, 3'h5, 32'h1, 1'h1);
        for (k = 0; k < 8; k++) begin
            if (k != 1 && k != 3 && k != 5) begin
                rd(5'h10, k[2:0], 32'h0, 1'h0);
            end
        end
        rd(5'h11, 3'h3, 32'h0, 1'h0);
        $display("test feature reads done");
        wr(3'h1);
        wr(3'h3);
        wr(3'h5);
        rd(5'h10, 3'h3, 32'h0023_7068, 1'h1);
        rd(5'h10, 3'h5, 32'h1, 1'h1);
        $display("test feature writes done");
        erl_ctl(1'h0, 1'h0, 1'h1, 1'h0);
        xl(1'h0, 32'h8000_0010, 1'h0, 1'h0, cfm_pkg::cfm_rgn_dram, 32'h10);
        xl(1'h0, 32'hA000_0010, 1'h0, 1'h0, cfm_pkg::cfm_rgn_dram, 32'h10);
        xl(1'h0, 32'h8400_0010, 1'h0, 1'h0, cfm_pkg::cfm_rgn_pflash, 32'h0400_0010);
        xl(1'h0, 32'hA400_0010, 1'h0, 1'h0, cfm_pkg::cfm_rgn_pflash, 32'h0400_0010);
        xl(1'h0, 32'h8800_0004, 1'h0, 1'h1, cfm_pkg::cfm_rgn_none, 32'h0);
        xl(1'h0, 32'hA800_0004, 1'h0, 1'h0, cfm_pkg::cfm_rgn_bflash, 32'h0800_0004);
        xl(1'h0, 32'h8C00_0000, 1'h0, 1'h1, cfm_pkg::cfm_rgn_none, 32'h0);
        xl(1'h0, 32'hAC00_0100, 1'h0, 1'h0, cfm_pkg::cfm_rgn_periph, 32'h0C00_0100);
        xl(1'h0, 32'h8000_0100, 1'h1, 1'h0, cfm_pkg::cfm_rgn_dram, 32'h100);
        xl(1'h0, 32'hA100_0000, 1'h0, 1'h1, cfm_pkg::cfm_rgn_none, 32'h0);
        xl(1'h0, 32'h0400_0020, 1'h0, 1'h1, cfm_pkg::cfm_rgn_none, 32'h0);
        xl(1'h0, 32'hC000_0000, 1'h0, 1'h1, cfm_pkg::cfm_rgn_none, 32'h0);
        $display("test virtual map done");
        erl_ctl(1'h0, 1'h1, 1'h1, 1'h1);
        xl(1'h0, 32'h0400_0020, 1'h1, 1'h0, cfm_pkg::cfm_rgn_pflash, 32'h0400_0020);
        xl(1'h0, 32'hA800_0004, 1'h0, 1'h0, cfm_pkg::cfm_rgn_bflash, 32'h0800_0004);
        erl_ctl(1'h0, 1'h0, 1'h1, 1'h0);
        erl_ctl(1'h1, 1'h0, 1'h0, 1'h1);
        erl_ctl(1'h0, 1'h0, 1'h1, 1'h0);
        $display("test error level done");
        // other masters stay physical, checked here with the error level clear
        xl(1'h1, 32'h0800_0004, 1'h0, 1'h0, cfm_pkg::cfm_rgn_bflash, 32'h0800_0004);
        xl(1'h1, 32'h0C00_0040, 1'h0, 1'h0, cfm_pkg::cfm_rgn_periph, 32'h0C00_0040);
        xl(1'h1, 32'h1000_0000, 1'h0, 1'h1, cfm_pkg::cfm_rgn_none, 32'h0);
        $display("test other master done");
        // second reset in mid-run must raise the flag again and swallow requests
        @(negedge clock_in);
        rst_in = 1'h1;
        rd_sel = '{en: 1'h1, num: 5'h10, sel: 3'h1};
        cpu_req = 1'h1;
        cpu_vaddr = 32'hA000_0010;
        @(negedge clock_in);
        rst_in = 1'h0;
        rd_sel = '0;
        cpu_req = 1'h0;
        check("erl_rerst", {31'h0, error_level_flag}, 32'h1);
        check("rd_rerst", rd_data, 32'h0);
        check("hit_rerst", {31'h0, rd_hit}, 32'h0);
        check("map_rerst", {31'h0, cpu_map.valid}, 32'h0);
        @(negedge clock_in);
        $display("test second reset done");
        complete_run();
    end
endmodule

`default_nettype wire

// ==== verilog/cfm_core_cfg.sv ====
// core feature registers (selects 1, 3, 5) and fixed segment translation
// assumes the coprocessor read/write strobes and cpu requests are one-cycle
// pulses synchronous to clock_in; the status register lives elsewhere
//
// Functional notes
// - select-1 bit 31 reads one, announcing the select-2 register.
// - select-1 bits 30 to 5 read zero.
// - select-1 reports perf counters and debug port present, others absent.
// - select-3 interrupt level width code 01, eight-bit priority fields.
// - select-3 instruction set code 01, compact isa revision 000.
// - select-3 bit 16 set; exceptions enter in compact instruction set.
// - select-3 micro ase, user local, read-exec inhibit set; flow trace clear.
// - select-3 external interrupt controller and vectored interrupts supported.
// - select-3 small pages clear, device memory map set, trace clear.
// - select-3 bit 31 and unimplemented bits read zero.
// - select-5 bit 0 nested fault set, all else zero.
// - one 4-Gbyte virtual space, every address naming at most one resource.
// - two 512-Mbyte segments mapped by the fixed translation unit.
// - flash and ram via both segments; boot flash, peripherals high only.
// - error level flag set on reset, soft reset or nmi.
// - flag set gives physical addressing at low addresses; cleared restores the virtual map.
// - instruction fetch from data ram is permitted.
// - other bus masters use physical addresses, untranslated.
`include "cfm_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module cfm_core_cfg #(
    parameter logic [31:0] DRAM_BASE = `CFM_DRAM_BASE,
    parameter logic [31:0] PFLASH_BASE = `CFM_PFLASH_BASE,
    parameter logic [31:0] BFLASH_BASE = `CFM_BFLASH_BASE,
    parameter logic [31:0] PERIPH_BASE = `CFM_PERIPH_BASE,
    parameter int WIN_BITS = `CFM_WIN_BITS
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // coprocessor register read
    input wire cfm_pkg::cfm_cp0_sel_t rd_sel_in,
    output var logic [31:0] rd_data_out,
    output var logic rd_hit_out,
    // coprocessor register write
    input wire cfm_pkg::cfm_cp0_sel_t wr_sel_in,
    output var logic wr_hit_out,
    // error level control
    input wire logic soft_reset_in,
    input wire logic nmi_in,
    input wire logic erl_clear_in,
    output var logic erl_out,
    // cpu translation
    input wire logic cpu_req_in,
    input wire logic cpu_fetch_in,
    input wire logic [31:0] cpu_vaddr_in,
    output var cfm_pkg::cfm_map_t cpu_map_out,
    // other bus masters
    input wire logic dma_req_in,
    input wire logic [31:0] dma_addr_in,
    output var cfm_pkg::cfm_map_t dma_map_out
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // windows must sit inside the 512-Mbyte physical space
    if (WIN_BITS < 1 || WIN_BITS > 29) begin : g_bad_win
        $error("window width out of range");
    end

    // ************************************************************
    // fixed feature values
    // ************************************************************
    logic [31:0] feat_one;
    logic [31:0] feat_three;
    logic [31:0] feat_five;

    always_comb begin
        feat_one = 32'h0000_0000;
        feat_one[`CFM_C1_NEXT_PRESENT] = 1'h1;
        feat_one[`CFM_C1_PERF] = 1'h1;
        feat_one[`CFM_C1_WATCH] = 1'h0;
        feat_one[`CFM_C1_COMPRESSED] = 1'h0;
        feat_one[`CFM_C1_DEBUG] = 1'h1;
        feat_one[`CFM_C1_FLOAT] = 1'h0;
    end

    always_comb begin
        feat_three = 32'h0000_0000;
        feat_three[`CFM_C3_NEXT_PRESENT] = 1'h0;
        feat_three[`CFM_C3_IRQ_LEVEL_W +: 2] = `CFM_IRQ_LEVEL_W_CODE;
        feat_three[`CFM_C3_ISA_REV +: 3] = `CFM_ISA_REV_CODE;
        feat_three[`CFM_C3_ISA_AVAIL +: 2] = `CFM_ISA_AVAIL_CODE;
        // exception vectors are entered in the compact set
        feat_three[`CFM_C3_EXC_ENTRY] = 1'h1;
        feat_three[`CFM_C3_MICRO_ASE] = 1'h1;
        feat_three[`CFM_C3_USER_LOCAL] = 1'h1;
        feat_three[`CFM_C3_READ_EXEC] = 1'h1;
        feat_three[`CFM_C3_FLOW_TRACE] = 1'h0;
        feat_three[`CFM_C3_EXT_IRQ] = 1'h1;
        feat_three[`CFM_C3_VEC_IRQ] = 1'h1;
        feat_three[`CFM_C3_SMALL_PAGE] = 1'h0;
        feat_three[`CFM_C3_DEV_MAP] = 1'h1;
        feat_three[`CFM_C3_TRACE] = 1'h0;
    end

    always_comb begin
        feat_five = 32'h0000_0000;
        feat_five[`CFM_C5_NESTED_FAULT] = 1'h1;
    end

    // ************************************************************
    // coprocessor read and write
    // ************************************************************
    logic rd_mine;
    logic [31:0] next_rd_data;

    assign rd_mine = rd_sel_in.en && rd_sel_in.num == `CFM_REG_NUM;

    always_comb begin
        next_rd_data = 32'h0000_0000;
        if (rd_mine) begin
            case (rd_sel_in.sel)
                `CFM_SEL_ONE: next_rd_data = feat_one;
                `CFM_SEL_THREE: next_rd_data = feat_three;
                `CFM_SEL_FIVE: next_rd_data = feat_five;
                default: next_rd_data = 32'h0000_0000;
            endcase
        end
    end

    // selects 0 and 2 belong to another block, so no hit is claimed
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rd_data_out <= 32'h0000_0000;
            rd_hit_out <= 1'h0;
        end else begin
            rd_data_out <= next_rd_data;
            rd_hit_out <= rd_mine && (rd_sel_in.sel == `CFM_SEL_ONE ||
                rd_sel_in.sel == `CFM_SEL_THREE || rd_sel_in.sel == `CFM_SEL_FIVE);
        end
    end

    // writes are acknowledged and dropped; no storage exists to change
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wr_hit_out <= 1'h0;
        end else begin
            wr_hit_out <= wr_sel_in.en && wr_sel_in.num == `CFM_REG_NUM &&
                (wr_sel_in.sel == `CFM_SEL_ONE || wr_sel_in.sel == `CFM_SEL_THREE ||
                wr_sel_in.sel == `CFM_SEL_FIVE);
        end
    end

    // ************************************************************
    // error level flag
    // ************************************************************
    // set beats clear so an nmi during the clear is never lost
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            erl_out <= `CFM_ERL_RESET;
        end else if (soft_reset_in || nmi_in) begin
            erl_out <= 1'h1;
        end else if (erl_clear_in) begin
            erl_out <= 1'h0;
        end
    end

    // ************************************************************
    // physical region decode
    // ************************************************************
    function automatic cfm_pkg::cfm_region_t region_of(input logic [31:0] pa);
        logic [31:0] top;
        top = pa >> WIN_BITS;
        if (top == (DRAM_BASE >> WIN_BITS)) begin
            region_of = cfm_pkg::cfm_rgn_dram;
        end else if (top == (PFLASH_BASE >> WIN_BITS)) begin
            region_of = cfm_pkg::cfm_rgn_pflash;
        end else if (top == (BFLASH_BASE >> WIN_BITS)) begin
            region_of = cfm_pkg::cfm_rgn_bflash;
        end else if (top == (PERIPH_BASE >> WIN_BITS)) begin
            region_of = cfm_pkg::cfm_rgn_periph;
        end else begin
            region_of = cfm_pkg::cfm_rgn_none;
        end
    endfunction

    // ************************************************************
    // cpu fixed translation
    // ************************************************************
    // each 32-bit address names one location in a 4-Gbyte space
    cfm_pkg::cfm_map_t next_cpu_map;
    logic [2:0] seg;
    logic [31:0] seg_off;

    assign seg = cpu_vaddr_in[31:29];
    assign seg_off = {3'h0, cpu_vaddr_in[28:0]};

    always_comb begin
        next_cpu_map = '0;
        next_cpu_map.valid = cpu_req_in;
        // fetch carries no restriction, data ram is executable
        next_cpu_map.fetch = cpu_fetch_in;
        next_cpu_map.paddr = seg_off;
        if (erl_out && seg == `CFM_SEG_PHYS) begin
            // flag set: low addresses reach physical space directly
            next_cpu_map.paddr = cpu_vaddr_in;
            next_cpu_map.region = region_of(cpu_vaddr_in);
            next_cpu_map.fault = next_cpu_map.region == cfm_pkg::cfm_rgn_none;
        end else begin
            next_cpu_map.region = region_of(seg_off);
            case (seg)
                `CFM_SEG_LOW: begin
                    // boot flash and peripherals are high-window only
                    next_cpu_map.fault = next_cpu_map.region == cfm_pkg::cfm_rgn_none ||
                        next_cpu_map.region == cfm_pkg::cfm_rgn_bflash ||
                        next_cpu_map.region == cfm_pkg::cfm_rgn_periph;
                end
                `CFM_SEG_HIGH: begin
                    next_cpu_map.fault = next_cpu_map.region == cfm_pkg::cfm_rgn_none;
                end
                default: begin
                    // outside both 512-Mbyte windows nothing is mapped
                    next_cpu_map.fault = 1'h1;
                    next_cpu_map.region = cfm_pkg::cfm_rgn_none;
                end
            endcase
        end
        if (!cpu_req_in) begin
            next_cpu_map = '0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cpu_map_out <= '0;
        end else begin
            cpu_map_out <= next_cpu_map;
        end
    end

    // ************************************************************
    // other masters, physical pass-through
    // ************************************************************
    cfm_pkg::cfm_map_t next_dma_map;

    always_comb begin
        next_dma_map = '0;
        if (dma_req_in) begin
            next_dma_map.valid = 1'h1;
            next_dma_map.paddr = dma_addr_in;
            next_dma_map.region = region_of(dma_addr_in);
            next_dma_map.fault = next_dma_map.region == cfm_pkg::cfm_rgn_none;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            dma_map_out <= '0;
        end else begin
            dma_map_out <= next_dma_map;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    logic rd_one;
    logic rd_three;
    logic rd_five;

    assign rd_one = rd_mine && rd_sel_in.sel == `CFM_SEL_ONE;
    assign rd_three = rd_mine && rd_sel_in.sel == `CFM_SEL_THREE;
    assign rd_five = rd_mine && rd_sel_in.sel == `CFM_SEL_FIVE;

    sel_one_value_a: assert property (rd_one |=>
        rd_data_out == 32'h8000_0012 && rd_hit_out)
        else $error("select-1 value wrong");
    sel_three_value_a: assert property (rd_three |=> rd_data_out == 32'h0023_7068)
        else $error("select-3 value wrong");
    sel_five_value_a: assert property (rd_five |=> rd_data_out == 32'h0000_0001)
        else $error("select-5 value wrong");
    write_no_effect_a: assert property (wr_sel_in.en ##[1:2] rd_three |=>
        rd_data_out == 32'h0023_7068)
        else $error("write changed select-3");
    erl_event_set_a: assert property ((soft_reset_in || nmi_in) |=> erl_out)
        else $error("error level not set");
    erl_clear_a: assert property (erl_clear_in && !soft_reset_in && !nmi_in |=> !erl_out)
        else $error("error level not cleared");
    erl_reset_a: assert property (@(posedge clock_in) disable iff (1'h0) rst_in |=> erl_out)
        else $error("error level not set by reset");
    low_seg_map_a: assert property (cpu_req_in && !erl_out &&
        cpu_vaddr_in[31:29] == 3'h4
        |=> cpu_map_out.paddr == {3'h0, $past(cpu_vaddr_in[28:0])})
        else $error("low window translation wrong");
    boot_low_fault_a: assert property (cpu_req_in && !erl_out &&
        cpu_vaddr_in[31:29] == 3'h4 &&
        region_of(seg_off) == cfm_pkg::cfm_rgn_bflash |=> cpu_map_out.fault)
        else $error("boot flash reachable from low window");
    erl_phys_a: assert property (cpu_req_in && erl_out && cpu_vaddr_in[31:29] == 3'h0
        |=> cpu_map_out.paddr == $past(cpu_vaddr_in))
        else $error("physical addressing under error level wrong");
    dram_fetch_a: assert property (cpu_req_in && cpu_fetch_in &&
        cpu_vaddr_in[31:30] == 2'h2 && region_of(seg_off) == cfm_pkg::cfm_rgn_dram
        |=> cpu_map_out.valid && !cpu_map_out.fault)
        else $error("fetch from data ram refused");
    dma_pass_a: assert property (dma_req_in |=> dma_map_out.valid &&
        dma_map_out.paddr == $past(dma_addr_in))
        else $error("other master address translated");
    dma_no_fetch_a: assert property (dma_req_in |=> !dma_map_out.fetch)
        else $error("other master marked as fetch");
    dma_fault_a: assert property (dma_req_in &&
        region_of(dma_addr_in) == cfm_pkg::cfm_rgn_none |=> dma_map_out.fault)
        else $error("other master reached an unmapped region");
    high_seg_map_a: assert property (cpu_req_in && cpu_vaddr_in[31:29] == 3'h5
        |=> cpu_map_out.paddr == {3'h0, $past(cpu_vaddr_in[28:0])})
        else $error("high window translation wrong");
    periph_low_fault_a: assert property (cpu_req_in && cpu_vaddr_in[31:29] == 3'h4 &&
        region_of(seg_off) == cfm_pkg::cfm_rgn_periph |=> cpu_map_out.fault)
        else $error("peripherals reachable from low window");
    outside_fault_a: assert property (cpu_req_in && cpu_vaddr_in[31:30] != 2'h2 &&
        !(erl_out && cpu_vaddr_in[31:29] == 3'h0) |=> cpu_map_out.fault)
        else $error("address outside both windows mapped");

    // idle and refused cases: outputs fall back to zero; then write acknowledge and flag hold checks
    map_idle_a: assert property (!cpu_req_in |=> !cpu_map_out.valid &&
        !cpu_map_out.fault && cpu_map_out.paddr == 32'h0000_0000)
        else $error("translation output without request");
    read_idle_a: assert property (!rd_sel_in.en |=>
        rd_data_out == 32'h0000_0000 && !rd_hit_out)
        else $error("read data without request");
    unowned_read_a: assert property (rd_sel_in.en && rd_sel_in.num != 5'h10 |=>
        rd_data_out == 32'h0000_0000 && !rd_hit_out)
        else $error("read of another register answered");
    write_hit_a: assert property (wr_sel_in.en && wr_sel_in.num == 5'h10 &&
        wr_sel_in.sel == 3'h3 |=> wr_hit_out)
        else $error("feature register write not acknowledged");
    erl_hold_a: assert property (!soft_reset_in && !nmi_in &&
        !erl_clear_in |=> $stable(erl_out))
        else $error("error level changed without cause");

    read_sel3_c: cover property (rd_three ##1 rd_hit_out);
    low_map_c: cover property (cpu_req_in && !erl_out && seg == 3'h4 ##1 !cpu_map_out.fault);
    erl_drop_c: cover property (erl_out ##1 !erl_out ##[1:4] cpu_map_out.valid);
    dma_c: cover property (dma_req_in ##1 dma_map_out.valid);
    erl_phys_c: cover property (cpu_req_in && erl_out && seg == 3'h0 ##1 !cpu_map_out.fault);

endmodule

`default_nettype wire

// ==== verilog/cfm_defines.svh ====
// constants of the core feature registers and the fixed segment map
// assumes inclusion by bare name from the design file
`ifndef CFM_DEFINES_SVH
`define CFM_DEFINES_SVH

// coprocessor register number and selects
`define CFM_REG_NUM 5'h10
`define CFM_SEL_ONE 3'h1
`define CFM_SEL_THREE 3'h3
`define CFM_SEL_FIVE 3'h5

// select-1 field positions
`define CFM_C1_NEXT_PRESENT 31
`define CFM_C1_PERF 4
`define CFM_C1_WATCH 3
`define CFM_C1_COMPRESSED 2
`define CFM_C1_DEBUG 1
`define CFM_C1_FLOAT 0

// select-3 field positions
`define CFM_C3_NEXT_PRESENT 31
`define CFM_C3_IRQ_LEVEL_W 21
`define CFM_C3_ISA_REV 18
`define CFM_C3_MICRO_ASE 17
`define CFM_C3_EXC_ENTRY 16
`define CFM_C3_ISA_AVAIL 14
`define CFM_C3_USER_LOCAL 13
`define CFM_C3_READ_EXEC 12
`define CFM_C3_FLOW_TRACE 8
`define CFM_C3_EXT_IRQ 6
`define CFM_C3_VEC_IRQ 5
`define CFM_C3_SMALL_PAGE 4
`define CFM_C3_DEV_MAP 3
`define CFM_C3_TRACE 0

// select-5 field positions
`define CFM_C5_NESTED_FAULT 0

// multi-bit field values
`define CFM_IRQ_LEVEL_W_CODE 2'h1
`define CFM_ISA_REV_CODE 3'h0
`define CFM_ISA_AVAIL_CODE 2'h1

// reset value of the error level flag
`define CFM_ERL_RESET 1'h1

// segment codes in virtual bits 31:29
`define CFM_SEG_PHYS 3'h0
`define CFM_SEG_LOW 3'h4
`define CFM_SEG_HIGH 3'h5

// physical region windows
`define CFM_DRAM_BASE 32'h0000_0000
`define CFM_PFLASH_BASE 32'h0400_0000
`define CFM_BFLASH_BASE 32'h0800_0000
`define CFM_PERIPH_BASE 32'h0C00_0000
`define CFM_WIN_BITS 24

`endif

// ==== verilog/cfm_pkg.sv ====
// types shared by the core feature register and segment map block
// assumes the defines header is on the include path
package cfm_pkg;

    typedef enum logic [2:0] {
        cfm_rgn_none,
        cfm_rgn_pflash,
        cfm_rgn_dram,
        cfm_rgn_bflash,
        cfm_rgn_periph
    } cfm_region_t;

    typedef struct packed {
        logic en;
        logic [4:0] num;
        logic [2:0] sel;
    } cfm_cp0_sel_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic fetch;
        cfm_region_t region;
        logic [31:0] paddr;
    } cfm_map_t;

endpackage
